// [dv/lcd_panel_model.sv]
// Purpose: Far side stand-in: the panel board's free-running clock source
// Assumes: External panel clock runs free, unrelated to frames
// Notes:   Toggles on each rising system edge so every sample differs from the last
`timescale 1ns/1ps
module lcd_panel_model (
   input  wire logic clk_sys,                 // System clock
   output logic      external_panel_clock_in  // Clock offered to the mapper
);
   // ****************************************
   // Clock source
   // ****************************************
   logic tick_q = 1'b0;

   // Free-running toggle, so a stuck select shows at once
   always @(posedge clk_sys) begin
      tick_q <= ~tick_q;
   end
   assign external_panel_clock_in = tick_q;
endmodule // lcd_panel_model

// [dv/lcd_panel_pin_mapper_chk.sv]
// Purpose: Port-level assertions for the panel pin mapper
// Assumes: One cycle from inputs to pins, outputs live from 3rd edge after reset
// Notes:   Bound to the top module
`timescale 1ns/1ps
module lcd_panel_pin_mapper_chk (
   input wire logic        clk_sys,                 // Clock
   input wire logic        arst_n,                  // Reset, active low
   input wire logic [3:0]  panel_mode,              // Mode code
   input wire logic [15:0] pixel_upper,             // Upper word
   input wire logic [7:0]  pixel_lower,             // Lower word
   input wire logic        frame_pulse_in,          // Frame
   input wire logic        row_display_reset_in,    // Row reset
   input wire logic        line_pulse_in,           // Line
   input wire logic        supply_enable_in,        // Supply
   input wire logic        gate_driver_clock_in,    // Gate clock
   input wire logic        data_enable_in,          // Data enable
   input wire logic        line_start_left_in,      // Line start
   input wire logic        power_save_in,           // Power save
   input wire logic        reverse_in,              // Reverse
   input wire logic        pixel_clock_in,          // Internal clock
   input wire logic        external_panel_clock_in, // External clock
   input wire logic        external_clock_select,   // Clock select
   input wire logic        colour_order_select,     // Order select
   input wire logic [17:0] panel_data,              // Data lines
   input wire logic        frame_pulse_out,         // Frame pin
   input wire logic        line_pulse_out,          // Line pin
   input wire logic        panel_supply_enable,     // Supply pin
   input wire logic        panel_data_enable,       // Enable pin
   input wire logic        panel_power_save,        // Power save pin
   input wire logic        panel_reverse,           // Reverse pin
   input wire logic        panel_data_clock,        // Data clock pin
   input wire logic        order_error              // Order flag
);
   // ****************************************
   // Helper state
   // ****************************************
   logic [1:0]  cnt_q, cnt_d;
   logic [15:0] up_q;
   logic [7:0]  lo_q;
   logic        dd_q, tft_q, live;

   // Wait out the reset synchroniser before judging anything
   always_comb cnt_d = (cnt_q == 2'h3) ? cnt_q : cnt_q + 2'h1;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 2'h0;
         up_q  <= 16'h0000;
         lo_q  <= 8'h00;
         dd_q  <= 1'b0;
         tft_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         up_q  <= pixel_upper;
         lo_q  <= pixel_lower;
         dd_q  <= (panel_mode == 4'h9);
         tft_q <= (panel_mode >= 4'h6) && (panel_mode <= 4'h9);
      end
   end
   assign live = (cnt_q == 2'h3);

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   chk_mono4_lines: assert property (live && panel_mode == 4'h0 |=>
      panel_data == {14'h0000, up_q[3:0]}) else $error("mono 4-bit lines wrong");
   chk_mono_dual: assert property (live && panel_mode == 4'h3 |=>
      panel_data == {2'h0, lo_q, up_q[7:0]}) else $error("mono dual lines wrong");
   chk_colour_dual: assert property (live && panel_mode == 4'h5 |=>
      panel_data == {2'h0, lo_q, up_q[7:0]}) else $error("colour dual lines wrong");
   chk_tft555_map: assert property (live && panel_mode == 4'h6 |=> panel_data ==
      {up_q[14:10], 1'b0, up_q[9:5], 1'b0, up_q[4:0], up_q[15]}) else $error("555 map wrong");
   chk_tft565_map: assert property (live && panel_mode == 4'h7 |=> panel_data[17:13] ==
      up_q[14:10] && !panel_data[12] && !panel_data[6] && panel_data[0] == up_q[15])
      else $error("565 map wrong");
   chk_frame_pin: assert property (live |=> frame_pulse_out == (dd_q ?
      $past(row_display_reset_in) : $past(frame_pulse_in))) else $error("frame pin wrong");
   chk_line_pin: assert property (live |=> line_pulse_out == $past(line_pulse_in))
      else $error("line pin wrong");
   chk_supply_pin: assert property (live |=> panel_supply_enable == (dd_q ?
      $past(gate_driver_clock_in) : $past(supply_enable_in))) else $error("supply pin wrong");
   chk_enable_pin: assert property (live |=> panel_data_enable == (dd_q ?
      $past(line_start_left_in) : $past(data_enable_in))) else $error("enable pin wrong");
   chk_save_rev: assert property (live |=> panel_power_save == (dd_q && $past(power_save_in))
      && panel_reverse == (dd_q && $past(reverse_in))) else $error("save or reverse wrong");
   chk_clock_pin: assert property (live |=> panel_data_clock == ($past(external_clock_select) ?
      $past(external_panel_clock_in) : $past(pixel_clock_in))) else $error("data clock wrong");
   chk_order_flag: assert property (live |=> order_error ==
      (tft_q && $past(colour_order_select))) else $error("order flag wrong");

   cover property (live && panel_mode == 4'h9);
   cover property (live && external_clock_select);
   cover property (live && panel_mode == 4'h1);
endmodule // lcd_panel_pin_mapper_chk

bind lcd_panel_pin_mapper lcd_panel_pin_mapper_chk lcd_panel_pin_mapper_chk_i (
   .clk_sys, .arst_n, .panel_mode, .pixel_upper, .pixel_lower, .frame_pulse_in,
   .row_display_reset_in, .line_pulse_in, .supply_enable_in, .gate_driver_clock_in,
   .data_enable_in, .line_start_left_in, .power_save_in, .reverse_in, .pixel_clock_in,
   .external_panel_clock_in, .external_clock_select, .panel_data, .frame_pulse_out,
   .line_pulse_out, .panel_supply_enable, .panel_data_enable, .panel_power_save,
   .panel_reverse, .panel_data_clock, .colour_order_select, .order_error);

// [dv/tb_top.sv]
// Purpose: Self-checking bench for the panel pin mapper
// Assumes: Inputs change on falling edges, outputs one cycle later
// Notes:   Control inputs packed as frame,row,line,sup,gate,de,spl,ps,rev
`timescale 1ns/1ps
module tb_top;
   logic        clk_sys = 1'b0, arst_n = 1'b0, pix_clk = 1'b0, ext_sel = 1'b0, cos = 1'b0;
   logic [3:0]  mode = 4'h0;
   logic [15:0] up = 16'h0000;
   logic [7:0]  lo = 8'h00;
   logic [8:0]  ctl_in = 9'h000;
   logic [17:0] panel_data;
   wire  [5:0]  ctl_out;
   logic        data_clk, ext_clk, order_err;
   int          fail_count = 0, n_checks = 0;

   always #20 clk_sys = ~clk_sys;

   lcd_panel_model lcd_panel_model_i (.clk_sys(clk_sys), .external_panel_clock_in(ext_clk));

   // Colour order select held clear in every TFT mode
   lcd_panel_pin_mapper lcd_panel_pin_mapper_i (.clk_sys(clk_sys), .arst_n(arst_n),
      .panel_mode(mode), .colour_order_select(cos), .pixel_upper(up), .pixel_lower(lo),
      .frame_pulse_in(ctl_in[8]), .row_display_reset_in(ctl_in[7]), .line_pulse_in(ctl_in[6]),
      .supply_enable_in(ctl_in[5]), .gate_driver_clock_in(ctl_in[4]),
      .data_enable_in(ctl_in[3]), .line_start_left_in(ctl_in[2]), .power_save_in(ctl_in[1]),
      .reverse_in(ctl_in[0]), .pixel_clock_in(pix_clk), .external_panel_clock_in(ext_clk),
      .external_clock_select(ext_sel), .panel_data(panel_data), .frame_pulse_out(ctl_out[5]),
      .line_pulse_out(ctl_out[4]), .panel_supply_enable(ctl_out[3]),
      .panel_data_enable(ctl_out[2]), .panel_power_save(ctl_out[1]),
      .panel_reverse(ctl_out[0]), .panel_data_clock(data_clk), .order_error(order_err));

   // ****************************************
   // Reference mapping
   // ****************************************
   function automatic logic [17:0] exp_data(input logic [3:0] m, input logic [15:0] u,
                                            input logic [7:0] l);
      case (m)
         4'h0: exp_data = {14'h0000, u[3:0]};
         4'h1: exp_data = {6'h00, l[3:0], 4'h0, u[3:0]};
         4'h2, 4'h4: exp_data = {10'h000, u[7:0]};
         4'h3, 4'h5: exp_data = {2'h0, l, u[7:0]};
         4'h6, 4'h7, 4'h8, 4'h9: exp_data = {u[14:10], 1'b0, u[9:5], 1'b0, u[4:0], u[15]};
         default: exp_data = 18'h00000;
      endcase
   endfunction

   function automatic logic [5:0] exp_ctl(input logic [3:0] m, input logic [8:0] c);
      logic dd;
      dd = (m == 4'h9);
      exp_ctl = {dd ? c[7] : c[8], c[6], dd ? c[4] : c[5], dd ? c[2] : c[3], dd & c[1], dd & c[0]};
   endfunction

   // ****************************************
   // Bench tasks
   // ****************************************
   task automatic stop_test();
      if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check_val(input logic [17:0] got, input logic [17:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
         fail_count++;
      end
   endtask

   // Set inputs now, result shows at the next falling edge
   task automatic drive(input logic [3:0] m, input logic [15:0] u, input logic [7:0] l,
                        input logic [8:0] c);
      mode = m;
      up = u;
      lo = l;
      ctl_in = c;
      @(negedge clk_sys);
   endtask

   // Every mode code back to back, two bit patterns
   task automatic t_data_modes();
      logic [15:0] pats [2] = '{16'hffff, 16'ha5c3};
      for (int p = 0; p < 2; p++) begin
         for (int m = 0; m < 16; m++) begin
            drive(m[3:0], pats[p], pats[p][15:8], 9'h000);
            check_val(panel_data, exp_data(m[3:0], pats[p], pats[p][15:8]));
         end
      end
   endtask

   // Control pins in STN, TFT and direct-drive modes; order select set only in STN
   task automatic t_ctrl_pins();
      logic [3:0] modes [3] = '{4'h0, 4'h6, 4'h9};
      logic [8:0] pats [3] = '{9'h155, 9'h0aa, 9'h1ff};
      for (int i = 0; i < 9; i++) begin
         cos = (i < 3);
         drive(modes[i / 3], 16'hffff, 8'hff, pats[i % 3]);
         check_val({12'h000, ctl_out}, {12'h000, exp_ctl(modes[i / 3], pats[i % 3])});
         check_val(panel_data, exp_data(modes[i / 3], 16'hffff, 8'hff));
         check_val({17'h00000, order_err}, 18'h00000);
      end
   endtask

   // Internal then external source; model toggles after each sample
   task automatic t_clock_sel();
      for (int i = 0; i < 8; i++) begin
         ext_sel = i[2];
         pix_clk = i[0];
         @(negedge clk_sys);
         check_val({17'h00000, data_clk}, {17'h00000, i[2] ? ~ext_clk : pix_clk});
      end
   endtask

   // Reset in mid-run clears the pins, then mapping resumes
   task automatic t_reset_mid();
      drive(4'h6, 16'h1234, 8'h56, 9'h1ff);
      arst_n = 1'b0;
      @(negedge clk_sys);
      check_val(panel_data, 18'h00000);
      check_val({12'h000, ctl_out}, 18'h00000);
      arst_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      // Second release stage rose only on the last rising edge, so the pins are still low here
      check_val(panel_data, 18'h00000);
      @(negedge clk_sys);
      check_val(panel_data, exp_data(4'h6, 16'h1234, 8'h56));
      check_val({12'h000, ctl_out}, {12'h000, exp_ctl(4'h6, 9'h1ff)});
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      arst_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      t_data_modes();
      t_ctrl_pins();
      t_clock_sel();
      t_reset_mid();
      stop_test();
   end

   initial begin
      repeat (4000) @(posedge clk_sys);
      fail_count++;
      stop_test();
   end
endmodule // tb_top

// [verilog/lcd_bit_router.sv]
// Purpose: Combinational routing of pixel bits and control functions to panel lines
// Assumes: Inputs arrive unregistered; the top module registers the outputs
// Notes:   Colour order must be red-low; blue-low order is not remapped here
`timescale 1ns/1ps
module lcd_bit_router (
   input  wire logic [3:0]  mode,             // Panel mode code
   input  wire logic [15:0] pixel,            // Upper or TFT pixel word
   input  wire logic [7:0]  lower,            // Lower panel STN data
   input  wire logic        frame_in,         // Frame or vsync pulse
   input  wire logic        row_reset_in,     // Row display reset, direct drive
   input  wire logic        supply_in,        // Supply enable request
   input  wire logic        gate_clk_in,      // Gate driver clock, direct drive
   input  wire logic        de_in,            // Data enable or AC bias
   input  wire logic        spl_in,           // Line start left, direct drive
   input  wire logic        ps_in,            // Power save level
   input  wire logic        rev_in,           // Reverse level
   lcd_pix_if.src           pins              // Mapped result
);

   // ****************************************
   // Data line mapping per mode
   // ****************************************
   always_comb begin
      pins.data = lcd_pin_pkg::DATA_RST;
      case (lcd_pin_pkg::panel_mode_type'(mode))
         lcd_pin_pkg::MODE_MONO4_SINGLE: begin
            pins.data[3:0] = pixel[3:0];
         end
         lcd_pin_pkg::MODE_MONO4_DUAL: begin
            pins.data[3:0] = pixel[3:0];
            pins.data[11:8] = lower[3:0];
         end
         lcd_pin_pkg::MODE_MONO8_SINGLE, lcd_pin_pkg::MODE_COLOR_SINGLE: begin
            pins.data[7:0] = pixel[7:0];
         end
         lcd_pin_pkg::MODE_MONO8_DUAL, lcd_pin_pkg::MODE_COLOR_DUAL: begin
            pins.data[7:0] = pixel[7:0];
            pins.data[15:8] = lower;
         end
         lcd_pin_pkg::MODE_TFT_555I: begin
            // One intensity bit feeds all three colours, taken from bit 15
            pins.data[5:1]   = pixel[4:0];
            pins.data[11:7]  = pixel[9:5];
            pins.data[17:13] = pixel[14:10];
            pins.data[0]     = pixel[15];
         end
         lcd_pin_pkg::MODE_TFT_565, lcd_pin_pkg::MODE_DD_TFT: begin
            // Pixel word: red[4:0], green[10:5], blue[15:11]
            pins.data[5:1]   = pixel[4:0];
            pins.data[11:7]  = pixel[9:5];
            pins.data[13]    = pixel[10];
            pins.data[17:14] = pixel[14:11];
            pins.data[0]     = pixel[15];
         end
         lcd_pin_pkg::MODE_TFT_16BIT: begin
            pins.data[5:1]   = pixel[4:0];
            pins.data[11:7]  = pixel[9:5];
            pins.data[17:13] = pixel[14:10];
            pins.data[0]     = pixel[15];
         end
         default: begin
            pins.data = lcd_pin_pkg::DATA_RST;
         end
      endcase
   end

   // ****************************************
   // Shared control pins
   // ****************************************
   always_comb begin
      if (lcd_pin_pkg::panel_mode_type'(mode) == lcd_pin_pkg::MODE_DD_TFT) begin
         pins.frame_fn  = row_reset_in;
         pins.supply_fn = gate_clk_in;
         pins.enable_fn = spl_in;
         pins.ps_drive  = ps_in;
         pins.rev_drive = rev_in;
      end else begin
         pins.frame_fn  = frame_in;
         pins.supply_fn = supply_in;
         pins.enable_fn = de_in;
         pins.ps_drive  = lcd_pin_pkg::CTRL_RST;
         pins.rev_drive = lcd_pin_pkg::CTRL_RST;
      end
   end

endmodule // lcd_bit_router

// [verilog/lcd_panel_pin_mapper.sv]
// Purpose: Output mapping stage that places pixel and timing functions on panel pins
// Assumes: Pixel pipeline and timing generator are synchronous to clk_sys
// Notes:   All outputs registered; one cycle latency from inputs to pins
// Assumes: Software keeps colour order select clear in TFT modes
// Notes:   Direct drive lends data lines 6 and 12 to power save and reverse
// Notes:   Codes 10 to 15 leave every data line low
//
// Summary of operation
// - Mono STN upper bits go on data lines 3..0 (4-bit) or 7..0 (8-bit), single or dual.
// - Mono dual STN lower bits go on lines 11..8 (4-bit) or 15..8 (8-bit); single leaves them.
// - Colour STN upper eight bits go on lines 7..0, bit n on line n.
// - Colour dual STN lower eight bits go on lines 15..8, bit n on line n+8.
// - TFT 5:5:5+I puts red on 5..1, green on 11..7, blue on 17..13, intensity on 0.
// - TFT 5:6:5 puts red on 5..1, green 4..0 on 11..7, green5 on 13, blue 3..0 on 17..14, blue4 on 0.
// - The 5:5:5+I intensity is a single bit common to all three colours.
// - One pin carries frame pulse or vsync, or the row display reset in direct-drive TFT.
// - The line pulse output carries line or horizontal sync in every mode.
// - One pin is supply enable, or the gate driver clock in direct-drive TFT.
// - One pin is data enable or AC bias, or the left line start in direct-drive TFT.
// - Power save appears only in direct-drive TFT, else that pin is data line 6.
// - Panel reverse appears only in direct-drive TFT, else that pin is data line 12.
`timescale 1ns/1ps
module lcd_panel_pin_mapper (
   input  wire logic        clk_sys,                 // System clock, 25 MHz
   input  wire logic        arst_n,                  // Async reset, active low
   input  wire logic [3:0]  panel_mode,              // Panel mode code
   input  wire logic        colour_order_select,     // Must stay 0 for TFT mappings
   input  wire logic [15:0] pixel_upper,             // Upper or TFT pixel word
   input  wire logic [7:0]  pixel_lower,             // Lower panel STN data
   input  wire logic        frame_pulse_in,          // Frame or vsync from timing
   input  wire logic        row_display_reset_in,    // Row reset, direct drive
   input  wire logic        line_pulse_in,           // Line or hsync from timing
   input  wire logic        supply_enable_in,        // Supply enable request
   input  wire logic        gate_driver_clock_in,    // Gate clock, direct drive
   input  wire logic        data_enable_in,          // Data enable or AC bias
   input  wire logic        line_start_left_in,      // Line start left, direct drive
   input  wire logic        power_save_in,           // Power save level
   input  wire logic        reverse_in,              // Reverse level
   input  wire logic        pixel_clock_in,          // Internal panel clock level
   input  wire logic        external_panel_clock_in, // External clock pin level
   input  wire logic        external_clock_select,   // 1 selects external clock
   output logic [17:0]      panel_data,              // Panel data lines
   output logic             frame_pulse_out,         // Frame, vsync or row reset
   output logic             line_pulse_out,          // Line or hsync pulse
   output logic             panel_supply_enable,     // Supply enable or gate clock
   output logic             panel_data_enable,       // Data enable or line start
   output logic             panel_power_save,        // Power save, direct drive
   output logic             panel_reverse,           // Reverse, direct drive
   output logic             panel_data_clock,        // Panel data clock
   output logic             order_error              // Colour order set in TFT mode
);

   // ****************************************
   // Mode decode helpers
   // ****************************************
   // Direct drive hands the shared control pins to the row and column drivers
   function automatic logic is_direct_drive(input logic [3:0] mode);
      return lcd_pin_pkg::panel_mode_type'(mode) == lcd_pin_pkg::MODE_DD_TFT;
   endfunction

   // TFT mappings run from 5:5:5+I up to direct drive
   function automatic logic is_tft(input logic [3:0] mode);
      logic above_low;
      logic below_high;
      above_low  = mode >= 4'(lcd_pin_pkg::MODE_TFT_555I);
      below_high = mode <= 4'(lcd_pin_pkg::MODE_DD_TFT);
      return above_low && below_high;
   endfunction

   // ****************************************
   // Reset release synchroniser
   // ****************************************
   // Two-stage release chain
   logic rst_meta_d;
   logic rst_meta_q;
   logic rst_sync_d;
   logic rst_sync_q;

   // Only the second stage reads the first
   always_comb begin
      rst_meta_d = 1'b1;
      rst_sync_d = rst_meta_q;
   end

   // Release through two stages to avoid a metastable deassertion
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= rst_meta_d;
         rst_sync_q <= rst_sync_d;
      end
   end

   // ****************************************
   // Routing
   // ****************************************
   // Router is purely combinational; all timing comes from the flops below
   lcd_pix_if route ();

   lcd_bit_router u_router (
      .mode         (panel_mode),
      .pixel        (pixel_upper),
      .lower        (pixel_lower),
      .frame_in     (frame_pulse_in),
      .row_reset_in (row_display_reset_in),
      .supply_in    (supply_enable_in),
      .gate_clk_in  (gate_driver_clock_in),
      .de_in        (data_enable_in),
      .spl_in       (line_start_left_in),
      .ps_in        (power_save_in),
      .rev_in       (reverse_in),
      .pins         (route.src)
   );

   // ****************************************
   // Output stage next values
   // ****************************************
   // Next values
   logic [17:0] data_d;
   logic        frame_d;
   logic        line_d;
   logic        supply_d;
   logic        enable_d;
   logic        ps_d;
   logic        rev_d;
   logic        dclk_d;
   logic        err_d;

   // Registered values
   logic [17:0] data_q;
   logic        frame_q;
   logic        line_q;
   logic        supply_q;
   logic        enable_q;
   logic        ps_q;
   logic        rev_q;
   logic        dclk_q;
   logic        err_q;
   logic        dd_mode;
   logic        tft_mode;

   // Mode flags shared by the data and flag groups
   always_comb begin
      dd_mode  = is_direct_drive(panel_mode);
      tft_mode = is_tft(panel_mode);
   end

   // Shared data lines give way to power save and reverse in direct drive
   always_comb begin
      data_d = route.data;
      if (dd_mode) begin
         data_d[lcd_pin_pkg::PS_PIN]  = 1'b0;
         data_d[lcd_pin_pkg::REV_PIN] = 1'b0;
      end
   end

   // Control functions as picked per mode by the router; line pulse comes straight from its input
   always_comb begin
      ps_d     = route.ps_drive;
      rev_d    = route.rev_drive;
      frame_d  = route.frame_fn;
      line_d   = line_pulse_in;
      supply_d = route.supply_fn;
      enable_d = route.enable_fn;
   end

   // Clock is a sampled level, so it toggles at most at half clk_sys
   // A true clock mux needs a glitch-free cell; sampling trades rate for safety
   always_comb begin
      dclk_d = external_clock_select ? external_panel_clock_in
                                     : pixel_clock_in;
      // Flag only; reversed colour order is not remapped
      err_d  = tft_mode && colour_order_select;
   end

   // ****************************************
   // Output registers
   // ****************************************
   // Every pin idles low while the release chain holds reset
   always_ff @(posedge clk_sys or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         data_q   <= lcd_pin_pkg::DATA_RST;
         frame_q  <= lcd_pin_pkg::CTRL_RST;
         line_q   <= lcd_pin_pkg::CTRL_RST;
         supply_q <= lcd_pin_pkg::CTRL_RST;
         enable_q <= lcd_pin_pkg::CTRL_RST;
         ps_q     <= lcd_pin_pkg::CTRL_RST;
         rev_q    <= lcd_pin_pkg::CTRL_RST;
         dclk_q   <= lcd_pin_pkg::CTRL_RST;
         err_q    <= lcd_pin_pkg::CTRL_RST;
      end else begin
         data_q   <= data_d;
         frame_q  <= frame_d;
         line_q   <= line_d;
         supply_q <= supply_d;
         enable_q <= enable_d;
         ps_q     <= ps_d;
         rev_q    <= rev_d;
         dclk_q   <= dclk_d;
         err_q    <= err_d;
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   // Straight from the output flops
   assign panel_data          = data_q;
   assign frame_pulse_out     = frame_q;
   assign line_pulse_out      = line_q;
   assign panel_supply_enable = supply_q;
   assign panel_data_enable   = enable_q;
   assign panel_power_save    = ps_q;
   assign panel_reverse       = rev_q;
   assign panel_data_clock    = dclk_q;
   assign order_error         = err_q;

endmodule // lcd_panel_pin_mapper

// [verilog/lcd_pin_pkg.sv]
// Purpose: Shared constants and types for the panel pin mapper
// Assumes: One clock domain, no software-visible registers
// Notes:   Mode codes are enumerated, field positions are localparams
package lcd_pin_pkg;

   // ****************************************
   // Panel modes
   // ****************************************
   typedef enum logic [3:0] {
      MODE_MONO4_SINGLE,
      MODE_MONO4_DUAL,
      MODE_MONO8_SINGLE,
      MODE_MONO8_DUAL,
      MODE_COLOR_SINGLE,
      MODE_COLOR_DUAL,
      MODE_TFT_555I,
      MODE_TFT_565,
      MODE_TFT_16BIT,
      MODE_DD_TFT
   } panel_mode_type;

   // ****************************************
   // Widths and field positions
   // ****************************************
   localparam int DATA_W        = 18;
   localparam int PIXEL_W       = 16;
   localparam int STN_W         = 8;
   localparam int RED_LSB       = 0;
   localparam int GREEN_LSB     = 5;
   localparam int BLUE_LSB      = 11;
   localparam int RED_PIN_LSB   = 1;
   localparam int GREEN_PIN_LSB = 7;
   localparam int BLUE_PIN_LSB  = 13;
   localparam int LOWER_PIN_LSB = 8;
   localparam int PS_PIN        = 6;
   localparam int REV_PIN       = 12;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
   localparam logic              CTRL_RST = 1'b0;

endpackage

// [verilog/lcd_pix_if.sv]
// Purpose: Carries one mapped pixel word plus control functions between modules
// Assumes: Single clock, combinational path from mapper to top
// Notes:   Top module registers every field before it leaves the block
`timescale 1ns/1ps
interface lcd_pix_if;
   logic [17:0] data;        // Mapped data lines
   logic        frame_fn;    // Frame or row reset function
   logic        supply_fn;   // Supply enable or gate clock
   logic        enable_fn;   // Data enable or line start
   logic        ps_drive;    // Power save shares data line 6
   logic        rev_drive;   // Reverse shares data line 12

   modport src (output data, frame_fn, supply_fn, enable_fn, ps_drive, rev_drive);
   modport dst (input  data, frame_fn, supply_fn, enable_fn, ps_drive, rev_drive);
endinterface
